/* verilog/ccdc_core.sv */
// ccdc_core.sv: paged configuration registers, transmit coder and receive decoder
//
// Contract
// [R1] modulation pulse lasts 2*(width+1) device clock cycles
// [R2] start-of-frame pulse uses its own width register, same relation
// [R3] software uses 3Fh for most modes and 73h for fast label mode
// [R4] suppress bit set: the encoder sends no start-of-frame
// [R5] suppress bit set: the encoder sends no end-of-frame
// [R6] end-of-frame lasts 11 ETU when selector set, else 10 ETU
// [R7] guard field adds 0 to 7 ETU between characters
// [R8] start-of-frame low 10/11 ETU then high 2/3 ETU per code
// [R9] pulse count code 0..4 gives 1,2,4,8,16 pulses; others reserved
// [R10] protocol code 10 picks 14443 path, 01 the 15693 path
// [R11] bypass bit switches off the amplifier low-pass filter
// [R12] gain code selects 20, 24, 31 or 35 dB
// [R13] without multi-frame the receiver stops after one frame
// [R14] collision masking forces bits after a collision to zero
// [R15] framing field selects label, 14443 A, 15693 or 14443 B
// [R16] polarity bit inverts decoding of first half-bit modulation
// [R17] software keeps decoder bits 7 and 1 at zero
// [R18] software selects page 3 before touching receive registers
// [R19] pulse widths count cycles of the device clock
`timescale 1ns/1ns
`default_nettype none
`include "ccdc_cfg.svh"
module ccdc_core
  import ccdc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // modulation pulse requests
  input wire logic tx_pulse_req,
  input wire logic tx_sof_pulse_req,
  output logic tx_pulse_q,
  // type b frame transmit
  input wire logic tx_frame_start,
  input wire logic tx_data_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_last,
  output logic tx_data_ready_q,
  output logic tx_mod_q,
  output logic tx_busy_q,
  // receive decoder input
  input wire logic rx_arm,
  input wire logic rx_bit_valid,
  input wire logic rx_half1_mod,
  input wire logic rx_coll,
  input wire logic rx_frame_end,
  // receive decoder output
  output logic rx_active_q,
  output logic rx_bit_q,
  output logic rx_bit_valid_q,
  output logic rx_frame_done_q,
  // analog and path settings
  output logic [4:0] rx_pulses_per_bit_q,
  output logic rx_path_14443_q,
  output logic rx_path_15693_q,
  output logic rx_lowpass_bypass_q,
  output logic [1:0] rx_gain_q,
  output logic [1:0] rx_frame_format_q,
  output logic rx_bpsk_q
);
  // ****************************************
  // register file
  // ****************************************
  logic [2:0] page_q;
  logic [7:0] modulation_pulse_width_q;
  logic [7:0] start_frame_pulse_width_q;
  ccdc_typeb_t typeb_frame_shaping_q;
  ccdc_rxc1_t receiver_control_one_q;
  ccdc_dec_t decoder_settings_q;
  logic hit_page;
  logic hit_paged;

  // page register answers at the bottom of every page
  assign hit_page = (reg_addr[2:0] == 3'(`CCDC_A_PAGE));
  assign hit_paged = (reg_addr[5:3] == page_q); // R18

  // register writes
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      page_q <= `CCDC_R_PAGE;
      modulation_pulse_width_q <= `CCDC_R_MODW;
      start_frame_pulse_width_q <= `CCDC_R_SOFW;
      typeb_frame_shaping_q <= `CCDC_R_TYPB;
      receiver_control_one_q <= `CCDC_R_RXC1;
      decoder_settings_q <= `CCDC_R_DEC;
    end
    else if (reg_wr)
    begin
      if (hit_page)
        page_q <= reg_wdata[2:0];
      else if (hit_paged)
      begin
        case (reg_addr)
          `CCDC_A_MODW: modulation_pulse_width_q <= reg_wdata;
          `CCDC_A_SOFW: start_frame_pulse_width_q <= reg_wdata;
          `CCDC_A_TYPB: typeb_frame_shaping_q <= reg_wdata;
          `CCDC_A_RXC1: receiver_control_one_q <= reg_wdata;
          `CCDC_A_DEC: decoder_settings_q <= reg_wdata; // R17
          default: ;
        endcase
      end
    end
  end

  // register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      if (hit_page)
        reg_rdata_q <= {5'h00, page_q};
      else if (!hit_paged)
        reg_rdata_q <= 8'h00;
      else
      begin
        case (reg_addr)
          `CCDC_A_MODW: reg_rdata_q <= modulation_pulse_width_q;
          `CCDC_A_SOFW: reg_rdata_q <= start_frame_pulse_width_q;
          `CCDC_A_TYPB: reg_rdata_q <= typeb_frame_shaping_q;
          `CCDC_A_RXC1: reg_rdata_q <= receiver_control_one_q;
          `CCDC_A_DEC: reg_rdata_q <= decoder_settings_q;
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // modulation pulse generator
  // ****************************************
  logic [9:0] pulse_cnt_q; // ten bits: width ffh gives 512 cycles

  // pulse length 2*(width+1) core clock cycles; a new request restarts it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pulse_cnt_q <= 10'h000;
    else if (tx_sof_pulse_req)
      pulse_cnt_q <= {1'b0, start_frame_pulse_width_q, 1'b0} + 10'h002; // R2 R19
    else if (tx_pulse_req)
      pulse_cnt_q <= {1'b0, modulation_pulse_width_q, 1'b0} + 10'h002; // R1 R19
    else if (pulse_cnt_q != 10'h000)
      pulse_cnt_q <= pulse_cnt_q - 10'h001;
  end

  // pulse output goes high the cycle after the request
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tx_pulse_q <= 1'b0;
    else
      tx_pulse_q <= tx_sof_pulse_req || tx_pulse_req || (pulse_cnt_q > 10'h001);
  end

  // ****************************************
  // type b frame sequencer
  // ****************************************
  ccdc_tx_state_t tx_state_q;
  logic [7:0] etu_cnt_q;
  logic [3:0] units_q;
  logic [9:0] shift_q;
  logic last_q;
  logic etu_tick;
  logic phase_end;

  assign etu_tick = (etu_cnt_q == `CCDC_ETU_LAST);
  assign phase_end = etu_tick && (units_q == 4'h1);

  // elementary time unit prescaler, restarted on each phase load
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      etu_cnt_q <= 8'h00;
    else if (tx_state_q == CCDC_TX_IDLE || tx_state_q == CCDC_TX_WAIT || etu_tick)
      etu_cnt_q <= 8'h00;
    else
      etu_cnt_q <= etu_cnt_q + 8'h01;
  end

  // frame state machine: sof, characters with guard time, eof
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state_q <= CCDC_TX_IDLE;
      units_q <= 4'h0;
      shift_q <= 10'h3ff;
      last_q <= 1'b0;
      tx_data_ready_q <= 1'b0;
    end
    else
    begin
      tx_data_ready_q <= 1'b0;
      case (tx_state_q)
        CCDC_TX_IDLE:
          if (tx_frame_start)
          begin
            if (typeb_frame_shaping_q.sof_suppress) // R4
              tx_state_q <= CCDC_TX_WAIT;
            else
            begin
              tx_state_q <= CCDC_TX_SOFL;
              units_q <= typeb_frame_shaping_q.sof_len[1] ? `CCDC_LEN_LONG : `CCDC_LEN_SHORT; // R8
            end
          end
        CCDC_TX_SOFL:
          if (phase_end)
          begin
            tx_state_q <= CCDC_TX_SOFH;
            units_q <= typeb_frame_shaping_q.sof_len[0] ? `CCDC_HIGH_LONG : `CCDC_HIGH_SHORT; // R8
          end
          else if (etu_tick)
            units_q <= units_q - 4'h1;
        CCDC_TX_SOFH:
          if (phase_end)
            tx_state_q <= CCDC_TX_WAIT;
          else if (etu_tick)
            units_q <= units_q - 4'h1;
        CCDC_TX_WAIT:
          if (tx_data_valid)
          begin
            tx_state_q <= CCDC_TX_CHAR;
            units_q <= `CCDC_CHAR_ETU;
            shift_q <= {1'b1, tx_data, 1'b0};
            last_q <= tx_data_last;
            tx_data_ready_q <= 1'b1;
          end
        CCDC_TX_CHAR:
          if (phase_end)
          begin
            if (!last_q && typeb_frame_shaping_q.guard_etu != 3'h0)
            begin
              tx_state_q <= CCDC_TX_GUARD;
              units_q <= {1'b0, typeb_frame_shaping_q.guard_etu}; // R7
            end
            else if (!last_q)
              tx_state_q <= CCDC_TX_WAIT;
            else if (typeb_frame_shaping_q.eof_suppress) // R5
              tx_state_q <= CCDC_TX_IDLE;
            else
            begin
              tx_state_q <= CCDC_TX_EOF;
              units_q <= typeb_frame_shaping_q.eof_long ? `CCDC_LEN_LONG : `CCDC_LEN_SHORT; // R6
            end
            shift_q <= 10'h3ff;
          end
          else if (etu_tick)
          begin
            units_q <= units_q - 4'h1;
            shift_q <= {1'b1, shift_q[9:1]};
          end
        CCDC_TX_GUARD, CCDC_TX_EOF:
          if (phase_end)
            tx_state_q <= (tx_state_q == CCDC_TX_GUARD) ? CCDC_TX_WAIT : CCDC_TX_IDLE;
          else if (etu_tick)
            units_q <= units_q - 4'h1;
        default:
          tx_state_q <= CCDC_TX_IDLE;
      endcase
    end
  end

  // line level: modulated while sof low, eof and zero bits
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_mod_q <= 1'b0;
      tx_busy_q <= 1'b0;
    end
    else
    begin
      tx_mod_q <= (tx_state_q == CCDC_TX_SOFL) || (tx_state_q == CCDC_TX_EOF)
                  || (tx_state_q == CCDC_TX_CHAR && !shift_q[0]);
      tx_busy_q <= (tx_state_q != CCDC_TX_IDLE);
    end
  end

  // ****************************************
  // receive decoder
  // ****************************************
  logic coll_seen_q;

  // receiver stays armed across frames only in multi-frame mode
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_active_q <= 1'b0;
      coll_seen_q <= 1'b0;
      rx_frame_done_q <= 1'b0;
    end
    else
    begin
      rx_frame_done_q <= rx_active_q && rx_frame_end;
      if (rx_arm)
        rx_active_q <= 1'b1;
      else if (rx_active_q && rx_frame_end && !decoder_settings_q.multi)
        rx_active_q <= 1'b0; // R13
      if (rx_active_q && rx_bit_valid && rx_coll)
        coll_seen_q <= 1'b1;
      else if (rx_arm || rx_frame_end)
        coll_seen_q <= 1'b0;
    end
  end

  // bit value from first half-bit modulation, masked after a collision
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_bit_q <= 1'b0;
      rx_bit_valid_q <= 1'b0;
    end
    else
    begin
      rx_bit_valid_q <= rx_active_q && rx_bit_valid;
      if (rx_active_q && rx_bit_valid)
        rx_bit_q <= (rx_half1_mod ^ decoder_settings_q.invert) // R16
                    && !(decoder_settings_q.coll_mask && coll_seen_q); // R14
    end
  end

  // analog and path settings decoded for the receiver front end
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_pulses_per_bit_q <= 5'h00;
      rx_path_14443_q <= 1'b0;
      rx_path_15693_q <= 1'b0;
    end
    else
    begin
      rx_pulses_per_bit_q <= (receiver_control_one_q.pulse_code > 3'h4) ? 5'h00 :
                             5'(5'h01 << receiver_control_one_q.pulse_code); // R9
      rx_path_14443_q <= (receiver_control_one_q.proto == 2'b10); // R10
      rx_path_15693_q <= (receiver_control_one_q.proto == 2'b01); // R10
    end
  end

  assign rx_lowpass_bypass_q = receiver_control_one_q.lp_bypass; // R11
  assign rx_gain_q = receiver_control_one_q.gain; // R12
  assign rx_frame_format_q = decoder_settings_q.framing; // R15
  assign rx_bpsk_q = decoder_settings_q.bit_enc;

  // ****************************************
  // assertions
  // ****************************************
  sequence req_normal_s;
    tx_pulse_req && !tx_sof_pulse_req && !tx_pulse_q;
  endsequence

  pulse_start_a: assert property (@(posedge core_clk) disable iff (rst) // R1
    req_normal_s |=> tx_pulse_q)
    else $error("pulse did not start");
  pulse_len_a: assert property (@(posedge core_clk) disable iff (rst) // R1
    tx_pulse_req && !tx_sof_pulse_req
      |=> pulse_cnt_q == {1'b0, $past(modulation_pulse_width_q), 1'b0} + 10'h002)
    else $error("pulse length wrong");
  sof_len_a: assert property (@(posedge core_clk) disable iff (rst) // R2
    tx_sof_pulse_req
      |=> tx_pulse_q && pulse_cnt_q == {1'b0, $past(start_frame_pulse_width_q), 1'b0} + 10'h002)
    else $error("sof pulse not loaded");
  sof_skip_a: assert property (@(posedge core_clk) disable iff (rst) // R4
    tx_state_q == CCDC_TX_IDLE && tx_frame_start && typeb_frame_shaping_q.sof_suppress
      |=> tx_state_q == CCDC_TX_WAIT)
    else $error("sof not suppressed");
  eof_skip_a: assert property (@(posedge core_clk) disable iff (rst) // R5
    tx_state_q == CCDC_TX_CHAR && phase_end && last_q && typeb_frame_shaping_q.eof_suppress
      |=> tx_state_q == CCDC_TX_IDLE)
    else $error("eof not suppressed");
  eof_units_a: assert property (@(posedge core_clk) disable iff (rst) // R6
    tx_state_q == CCDC_TX_CHAR && phase_end && last_q && !typeb_frame_shaping_q.eof_suppress
      |=> units_q == (typeb_frame_shaping_q.eof_long ? `CCDC_LEN_LONG : `CCDC_LEN_SHORT))
    else $error("eof length wrong");
  rx_stop_a: assert property (@(posedge core_clk) disable iff (rst) // R13
    rx_active_q && rx_frame_end && !rx_arm && !decoder_settings_q.multi |=> !rx_active_q && rx_frame_done_q)
    else $error("receiver not stopped");
  coll_mask_a: assert property (@(posedge core_clk) disable iff (rst) // R14
    coll_seen_q && decoder_settings_q.coll_mask && rx_active_q && rx_bit_valid |=> rx_bit_valid_q && !rx_bit_q)
    else $error("bit after collision not zero");
  polarity_a: assert property (@(posedge core_clk) disable iff (rst) // R16
    rx_active_q && rx_bit_valid && !coll_seen_q
      |=> rx_bit_q == ($past(rx_half1_mod) ^ $past(decoder_settings_q.invert)))
    else $error("half-bit polarity wrong");
endmodule : ccdc_core
`default_nettype wire

/* verilog/ccdc_cfg.svh */
// ccdc_cfg.svh: addresses, reset values, receive page and timing counts
`ifndef CCDC_CFG_SVH
`define CCDC_CFG_SVH
`define CCDC_A_PAGE 6'h00
`define CCDC_A_MODW 6'h15
`define CCDC_A_SOFW 6'h16
`define CCDC_A_TYPB 6'h17
`define CCDC_A_RXC1 6'h19
`define CCDC_A_DEC 6'h1a
`define CCDC_R_PAGE 3'h0
`define CCDC_R_MODW 8'h13
`define CCDC_R_SOFW 8'h3f
`define CCDC_R_TYPB 8'h3b
`define CCDC_R_RXC1 8'h73
`define CCDC_R_DEC 8'h08
`define CCDC_PAGE_RX 3'h3
`define CCDC_ETU_CYC 8'h80
`define CCDC_ETU_LAST 8'h7f
`define CCDC_CHAR_ETU 4'ha
`define CCDC_LEN_SHORT 4'ha
`define CCDC_LEN_LONG 4'hb
`define CCDC_HIGH_SHORT 4'h2
`define CCDC_HIGH_LONG 4'h3
`endif

/* verilog/ccdc_pkg.sv */
// ccdc_pkg.sv: field layouts and state types of the coder/decoder block
package ccdc_pkg;
  typedef struct packed {
    logic sof_suppress;
    logic eof_suppress;
    logic eof_long;
    logic [2:0] guard_etu;
    logic [1:0] sof_len;
  } ccdc_typeb_t;
  typedef struct packed {
    logic [2:0] pulse_code;
    logic [1:0] proto;
    logic lp_bypass;
    logic [1:0] gain;
  } ccdc_rxc1_t;
  typedef struct packed {
    logic fixed7;
    logic multi;
    logic coll_mask;
    logic [1:0] framing;
    logic invert;
    logic fixed1;
    logic bit_enc;
  } ccdc_dec_t;
  typedef enum logic [2:0] {
    CCDC_TX_IDLE = 3'b000,
    CCDC_TX_SOFL = 3'b001,
    CCDC_TX_SOFH = 3'b010,
    CCDC_TX_WAIT = 3'b011,
    CCDC_TX_CHAR = 3'b100,
    CCDC_TX_GUARD = 3'b101,
    CCDC_TX_EOF = 3'b110
  } ccdc_tx_state_t;
endpackage : ccdc_pkg

/* tb/ccdc_card_model.sv */
// card side model: measures line runs and feeds decoded half-bit samples
`timescale 1ns/1ns
`default_nettype none
module ccdc_card_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // line from the reader
  input wire logic tx_mod,
  // bit stream toward the decoder
  output logic rx_bit_valid,
  output logic rx_half1_mod,
  output logic rx_coll
);
  // ****************************************
  // line run recorder and bit source
  // ****************************************
  int mod_runs[$];
  int idle_runs[$];
  int run_len;
  logic last_mod;

  initial
  begin
    rx_bit_valid = 1'b0;
    rx_half1_mod = 1'b0;
    rx_coll = 1'b0;
  end

  // each completed run of one line level is queued with its length in cycles
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      run_len <= 1;
      last_mod <= 1'b0;
    end
    else if (tx_mod === last_mod)
      run_len <= run_len + 1;
    else
    begin
      if (last_mod)
        mod_runs.push_back(run_len);
      else
        idle_runs.push_back(run_len);
      run_len <= 1;
      last_mod <= tx_mod;
    end
  end

  // one bit, then the sample lines stop showing the old value
  task automatic send_bit(input logic half1, input logic coll);
    @(posedge core_clk);
    rx_bit_valid <= 1'b1;
    rx_half1_mod <= half1;
    rx_coll <= coll;
    @(posedge core_clk);
    rx_bit_valid <= 1'b0;
    rx_half1_mod <= ~half1;
    rx_coll <= ~coll;
  endtask : send_bit
endmodule : ccdc_card_model
`default_nettype wire

/* tb/ccdc_core_tb_top.sv */
// self-checking testbench of the coder/decoder configuration block
`timescale 1ns/1ns
`default_nettype none
`include "ccdc_cfg.svh"
module ccdc_core_tb_top
  import ccdc_pkg::*;
;
  // ****************************************
  // stimulus, tasks and checks
  // ****************************************
  logic core_clk, rst, reg_wr, reg_rd, tx_pulse_req, tx_sof_pulse_req, tx_pulse_q;
  logic tx_frame_start, tx_data_valid, tx_data_last, tx_data_ready_q, tx_mod_q, tx_busy_q;
  logic rx_arm, rx_bit_valid, rx_half1_mod, rx_coll, rx_frame_end, rx_active_q, rx_bit_q;
  logic rx_bit_valid_q, rx_frame_done_q, rx_path_14443_q, rx_path_15693_q, rx_lowpass_bypass_q, rx_bpsk_q;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, tx_data, v;
  logic [4:0] rx_pulses_per_bit_q;
  logic [1:0] rx_gain_q, rx_frame_format_q;
  ccdc_typeb_t t;
  int bad_count, check_count, seed, n;

  ccdc_core dut (.core_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .tx_pulse_req,
    .tx_sof_pulse_req, .tx_pulse_q, .tx_frame_start, .tx_data_valid, .tx_data, .tx_data_last, .tx_data_ready_q,
    .tx_mod_q, .tx_busy_q, .rx_arm, .rx_bit_valid, .rx_half1_mod, .rx_coll, .rx_frame_end, .rx_active_q,
    .rx_bit_q, .rx_bit_valid_q, .rx_frame_done_q, .rx_pulses_per_bit_q, .rx_path_14443_q, .rx_path_15693_q,
    .rx_lowpass_bypass_q, .rx_gain_q, .rx_frame_format_q, .rx_bpsk_q);

  ccdc_card_model card (.core_clk, .rst, .tx_mod(tx_mod_q), .rx_bit_valid, .rx_half1_mod, .rx_coll);

  // 100 MHz device clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic fail();
    bad_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    results();
  endtask : fail

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask : rd

  // count high cycles of the pulse output over a window longer than any width
  task automatic pulse(input logic sof, input logic both, input int exp);
    @(posedge core_clk);
    tx_sof_pulse_req <= sof;
    tx_pulse_req <= both | ~sof;
    @(posedge core_clk);
    tx_sof_pulse_req <= 1'b0;
    tx_pulse_req <= 1'b0;
    n = 0;
    repeat (600)
    begin
      #1;
      if (tx_pulse_q === 1'b1)
        n++;
      @(posedge core_clk);
    end
    chk(n, exp);
  endtask : pulse

  // hold the byte until the ready pulse has been seen
  task automatic take();
    int i;
    i = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      i++;
      if (i > 5000)
        fail();
    end
    while (tx_data_ready_q !== 1'b1);
    @(posedge core_clk);
  endtask : take

  // two bytes fe, 7f: modulated runs are sof, start+bit0, start, bit7, eof
  task automatic frame(input ccdc_typeb_t f);
    int i;
    int exp_q[$];
    wr(`CCDC_A_TYPB, f);
    card.mod_runs.delete();
    card.idle_runs.delete();
    @(posedge core_clk);
    tx_frame_start <= 1'b1;
    tx_data_valid <= 1'b1;
    tx_data <= 8'hfe;
    tx_data_last <= 1'b0;
    @(posedge core_clk);
    tx_frame_start <= 1'b0;
    take();
    tx_data <= 8'h7f;
    tx_data_last <= 1'b1;
    take();
    tx_data_valid <= 1'b0;
    i = 0;
    while (tx_busy_q !== 1'b0)
    begin
      @(posedge core_clk);
      #1;
      i++;
      if (i > 20000)
        fail();
    end
    repeat (4) @(posedge core_clk);
    if (!f.sof_suppress)
      exp_q.push_back(128 * (10 + f.sof_len[1]));
    exp_q = {exp_q, 256, 128, 128};
    if (!f.eof_suppress)
      exp_q.push_back(128 * (10 + f.eof_long));
    chk(card.mod_runs.size(), exp_q.size());
    foreach (exp_q[k])
      chk(card.mod_runs[k], exp_q[k]);
    if (!f.sof_suppress)
      chk(card.idle_runs[1] inside {[128 * (2 + f.sof_len[0]) : 128 * (2 + f.sof_len[0]) + 3]}, 1);
    i = f.sof_suppress ? 1 : 2;
    chk(card.idle_runs[i] inside {[128 * (8 + f.guard_etu) : 128 * (8 + f.guard_etu) + 3]}, 1);
  endtask : frame

  task automatic rx_run(input logic multi, input logic mask);
    ccdc_dec_t d;
    logic h, hit;
    d = ccdc_dec_t'($random(seed));
    d.fixed7 = 1'b0;
    d.fixed1 = 1'b0;
    d.multi = multi;
    d.coll_mask = mask;
    d.invert = multi ^ mask;
    wr(`CCDC_A_DEC, d);
    @(posedge core_clk);
    #1;
    chk({rx_frame_format_q, rx_bpsk_q}, {d.framing, d.bit_enc});
    @(posedge core_clk);
    rx_arm <= 1'b1;
    @(posedge core_clk);
    rx_arm <= 1'b0;
    #1;
    chk(rx_active_q, 1'b1);
    hit = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      h = 1'($random(seed));
      card.send_bit(h, k == 3);
      #1;
      chk({rx_bit_valid_q, rx_bit_q}, {1'b1, (hit & mask) ? 1'b0 : h ^ d.invert});
      hit = hit | (k == 3);
    end
    @(posedge core_clk);
    rx_frame_end <= 1'b1;
    @(posedge core_clk);
    rx_frame_end <= 1'b0;
    #1;
    chk({rx_frame_done_q, rx_active_q}, {1'b1, multi});
    card.send_bit(1'b1, 1'b0);
    #1;
    chk(rx_bit_valid_q, multi);
  endtask : rx_run

  // main sequence
  initial
  begin
    seed = 16;
    rst = 1'b1;
    {reg_wr, reg_rd, tx_pulse_req, tx_sof_pulse_req, tx_frame_start, tx_data_valid} = 6'h00;
    {tx_data_last, rx_arm, rx_frame_end} = 3'h0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    tx_data = 8'h00;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({rx_pulses_per_bit_q, rx_path_14443_q, rx_path_15693_q}, {5'h08, 2'b10});
    chk({rx_lowpass_bypass_q, rx_gain_q, rx_frame_format_q, rx_bpsk_q}, 6'b011010);
    rd(6'h00, 8'h00);
    wr(6'h00, 8'h02);
    rd(`CCDC_A_MODW, 8'h13);
    rd(`CCDC_A_SOFW, 8'h3f);
    rd(`CCDC_A_TYPB, 8'h3b);
    rd(`CCDC_A_RXC1, 8'h00);
    wr(6'h10, 8'h03);
    rd(6'h18, 8'h03);
    rd(`CCDC_A_RXC1, 8'h73);
    rd(`CCDC_A_DEC, 8'h08);
    rd(6'h1f, 8'h00);
    wr(`CCDC_A_MODW, 8'h5a);
    for (int k = 0; k < 8; k++)
    begin
      v = {k[2:0], k[1:0], 1'($random(seed)), k[1:0]};
      wr(`CCDC_A_RXC1, v);
      @(posedge core_clk);
      #1;
      chk(rx_pulses_per_bit_q, (k < 5) ? (5'h01 << k) : 5'h00);
      chk({rx_path_14443_q, rx_path_15693_q}, {v[4:3] == 2'b10, v[4:3] == 2'b01});
      chk({rx_lowpass_bypass_q, rx_gain_q}, v[2:0]);
      rd(`CCDC_A_RXC1, v);
    end
    for (int j = 0; j < 4; j++)
      rx_run(j[0], j[1]);
    wr(6'h00, 8'h02);
    rd(`CCDC_A_MODW, 8'h13);
    for (int k = 0; k < 3; k++)
    begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
      wr(`CCDC_A_MODW, v);
      rd(`CCDC_A_MODW, v);
      pulse(1'b0, 1'b0, 2 * (v + 1));
    end
    wr(`CCDC_A_SOFW, 8'h73);
    pulse(1'b1, 1'b1, 232);
    for (int i = 0; i < 4; i++)
    begin
      t = ccdc_typeb_t'($random(seed));
      t.sof_len = i[1:0];
      t.sof_suppress = (i == 1);
      t.eof_suppress = (i == 2);
      t.eof_long = i[0];
      t.guard_etu = (i == 0) ? 3'h0 : (i == 3) ? 3'h7 : t.guard_etu;
      frame(t);
      rd(`CCDC_A_TYPB, t);
    end
    results();
  end
endmodule : ccdc_core_tb_top
`default_nettype wire
